// ==== tb_top.sv ====
// Purpose: self-checking bench for the usb address/status bank
// Assumes: one wait state per access, outputs registered
// Notes:   read results are checked from a queue of expected words
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // signals
  localparam logic [17:0] A_STA = {ufa_pkg::IDX_EVENT_STATUS, 2'b00};
  localparam logic [17:0] A_MSK = {ufa_pkg::IDX_EVENT_MASK, 2'b00};
  localparam logic [17:0] A_ADR = {ufa_pkg::IDX_FUNC_ADDR, 2'b00};
  localparam logic [17:0] A_UNM = 18'h00010;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        cyc = 1'b0;
  logic                        we = 1'b0;
  logic [17:0]                 adr = 18'h00000;
  logic [31:0]                 wdat = 32'h00000000;
  logic                        fres = 1'b0;
  logic                        ce = 1'b1;
  logic [3:0]                  sel = 4'h0;
  logic                        kick = 1'b0;
  logic [2:0]                  kind = 3'h0;
  logic [3:0]                  dly = 4'h0;
  logic                        ack, busy, irq, nak, wake;
  logic [31:0]                 rdat;
  logic [6:0]                  faddr;
  ufa_pkg::ufa_usb_events_type ev;
  logic [31:0]                 exp_q[$];
  logic [7:0]                  exp_sta, exp_msk, v;
  logic [6:0]                  exp_ad;
  logic                        ring;
  int                          error_cnt = 0;
  int                          total_checks = 0;
  int                          cyc_cnt = 0;
  int                          bitpos[6] = '{1, 2, 3, 5, 6, 7};

  // 25 MHz clock
  always #20 clk = ~clk;

  // ==========================================================
  // design and host model
  ufa_regs ufa_regs_inst (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(ce),
    .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
    .I_EVENTS(ev), .I_USB_FUNC_RESET(fres), .O_IRQ(irq),
    .O_EP0_FORCE_NAK(nak), .O_FUNC_ADDR(faddr), .O_RING_WAKE(wake));
  ufa_host_model ufa_host_model_inst (.i_clk(clk), .i_reset(rst),
    .i_kick(kick), .i_kind(kind), .i_delay(dly), .o_busy(busy),
    .o_events(ev));

  // ==========================================================
  // reporting
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error rdat expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_out(input string nm, input logic [6:0] e,
                         input logic [6:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // read data taken at the edge where ack is high
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc === 1'b1 && we === 1'b0 && ack === 1'b1) begin
      cmp_rd(exp_q.pop_front(), rdat);
    end
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================
  // bus and event tasks, entered just after a rising edge
  task automatic wb(input logic w, input logic [17:0] a,
                    input logic [31:0] d, input logic [3:0] s = 4'hf);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // hold the request until the edge that samples ack high
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h00000000);
  endtask

  task automatic evt(input int k);
    kind <= 3'(k);
    dly <= 4'($urandom_range(7, 0));
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    do begin
      @(negedge clk);
    end while (busy !== 1'b0);
    repeat (2) @(posedge clk);
    if (k == 1 && exp_sta[2]) exp_sta[0] = 1'b1;
    if (k == 2) ring = ~ring;
    if (k != 2 || ring) exp_sta[bitpos[k]] = 1'b1;
  endtask

  task automatic chk_out();
    @(negedge clk);
    cmp_out("irq", {6'h0, |(exp_sta & exp_msk)}, {6'h0, irq});
    cmp_out("nak", {6'h0, exp_sta[2]}, {6'h0, nak});
    cmp_out("wake", {6'h0, exp_sta[3]}, {6'h0, wake});
    cmp_out("faddr", exp_ad, faddr);
    @(posedge clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    v = 8'($urandom(32'h4210405c));
    exp_sta = 8'h00;
    exp_msk = 8'h00;
    exp_ad = 7'h00;
    ring = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(A_STA, 32'h0);
    rd(A_MSK, 32'h0);
    rd(A_ADR, 32'h0);
    chk_out();
    wb(1'b1, A_ADR, 32'hffffffff);
    exp_ad = 7'h7f;
    rd(A_ADR, 32'h7f);
    wb(1'b1, A_UNM, 32'hffffffff);
    rd(A_UNM, 32'h0);
    wb(1'b1, A_STA, 32'hffffffff);
    rd(A_STA, 32'h0);
    for (int r = 0; r < 3; r++) begin
      exp_msk = 8'($urandom);
      wb(1'b1, A_MSK, {24'h0, exp_msk});
      rd(A_MSK, {24'h0, exp_msk});
      for (int k = 0; k < 6; k++) begin
        evt(k);
        rd(A_STA, {24'h0, exp_sta});
        chk_out();
      end
      v = 8'($urandom);
      wb(1'b1, A_STA, {24'h0, v});
      exp_sta = exp_sta & ~v;
      rd(A_STA, {24'h0, exp_sta});
      chk_out();
    end
    // event and write-one clear meet in one cycle: the set wins
    kind <= 3'h0;
    dly <= 4'h0;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wb(1'b1, A_STA, 32'h00000002);
    exp_sta[1] = 1'b1;
    rd(A_STA, {24'h0, exp_sta});
    // a write with byte 0 deselected is ignored
    wb(1'b1, A_ADR, 32'h00000011, 4'he);
    rd(A_ADR, 32'h7f);
    // a frozen core ignores a function reset
    ce <= 1'b0;
    fres <= 1'b1;
    @(posedge clk);
    fres <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    chk_out();
    evt(5);
    fres <= 1'b1;
    @(posedge clk);
    fres <= 1'b0;
    @(posedge clk);
    exp_ad = 7'h00;
    rd(A_ADR, 32'h0);
    rd(A_STA, {24'h0, exp_sta});
    chk_out();
    test_done();
  end
endmodule

// ==== ufa_host_model.sv ====
// Purpose: usb host side model issuing bus and setup events
// Assumes: one core clock; requests only while o_busy is low
// Notes:   ring is a level, each ring request toggles it
`timescale 1ns/1ns
module ufa_host_model (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // request from the bench
  input  wire logic                   i_kick,
  input  wire logic [2:0]             i_kind,
  input  wire logic [3:0]             i_delay,
  // events toward the bank
  output logic                        o_busy,
  output ufa_pkg::ufa_usb_events_type o_events
);
  // ==========================================================
  // delay state
  logic [3:0] wait_reg;
  logic [2:0] kind_reg;
  logic [5:0] pulse_reg;
  logic       ring_reg;

  // random delay, then a single-cycle pulse (a ring_reg toggle for kind 2) so events arrive late too
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_reg  <= 4'h0;
      kind_reg  <= 3'h0;
      pulse_reg <= 6'h00;
      ring_reg  <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      pulse_reg <= 6'h00;
      if (i_kick) begin
        wait_reg <= i_delay;
        kind_reg <= i_kind;
        o_busy   <= 1'b1;
      end else if (o_busy && wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (o_busy) begin
        o_busy <= 1'b0;
        if (kind_reg == 3'h2) begin
          ring_reg <= ~ring_reg;
        end else begin
          pulse_reg[kind_reg] <= 1'b1;
        end
      end
    end
  end

  // ring stays a level; the others are pulses
  assign o_events = ufa_pkg::ufa_usb_events_type'(
    {pulse_reg[5:3], ring_reg, pulse_reg[1:0]});
endmodule

// ==== ufa_pkg.sv ====
// Purpose: shared constants and types for the usb address/status bank
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes:   register byte address is four times its index
package ufa_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADR_W = 18;
  localparam int DAT_W = 32;
  localparam int IDX_W = 16;

  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK   = 16'hfffd;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 16'hfffe;
  localparam logic [IDX_W-1:0] IDX_FUNC_ADDR    = 16'hffff;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK   = 8'h00;
  localparam logic [6:0] RST_FUNC_ADDR    = 7'h00;

  // ==========================================================
  // field positions
  localparam int FUNC_ADDR_MSB   = 6;
  localparam int BIT_OVERWRITE   = 0;
  localparam int BIT_WAKEUP      = 1;
  localparam int BIT_SETUP       = 2;
  localparam int BIT_RING        = 3;
  localparam int BIT_RSV         = 4;
  localparam int BIT_RESUME      = 5;
  localparam int BIT_SUSPEND     = 6;
  localparam int BIT_PORT_RESET  = 7;
  localparam int STATUS_W        = 8;

  // ==========================================================
  // hardware events from the usb engine and the uart pins
  typedef struct packed {
    logic port_reset;   // host started a port reset (pulse)
    logic suspend;      // suspend condition seen (pulse)
    logic resume;       // resume seen (pulse)
    logic ring_level;   // serial ring-indicate input (level)
    logic setup;        // setup packet stored (pulse)
    logic remote_wake;  // remote wake-up request (pulse)
  } ufa_usb_events_type;

endpackage

// ==== ufa_regs.sv ====
// Purpose: usb function address and usb event status registers
// Assumes: classic wishbone slave, one clock, inputs synchronous
// Notes:   one wait state per access; unmapped reads return zero
`timescale 1ns/1ns
module ufa_regs (
  // clock, reset, enable
  input  wire logic                       I_CORE_CLK,
  input  wire logic                       I_RESET,
  input  wire logic                       I_CE,
  // wishbone slave
  input  wire logic                       I_WB_CYC,
  input  wire logic                       I_WB_STB,
  input  wire logic                       I_WB_WE,
  input  wire logic [ufa_pkg::ADR_W-1:0]  I_WB_ADR,
  input  wire logic [3:0]                 I_WB_SEL,
  input  wire logic [ufa_pkg::DAT_W-1:0]  I_WB_DAT,
  output logic                            O_WB_ACK,
  output logic [ufa_pkg::DAT_W-1:0]       O_WB_DAT,
  // usb engine events
  input  wire ufa_pkg::ufa_usb_events_type I_EVENTS,
  input  wire logic                       I_USB_FUNC_RESET,
  // results
  output logic                            O_IRQ,
  output logic                            O_EP0_FORCE_NAK,
  output logic [6:0]                      O_FUNC_ADDR,
  output logic                            O_RING_WAKE
);

  // ==========================================================
  // decode helper
  function automatic logic idx_hit(
    input logic [ufa_pkg::ADR_W-1:0] adr,
    input logic [ufa_pkg::IDX_W-1:0] idx
  );
    idx_hit = (adr[ufa_pkg::ADR_W-1:2] == idx);
  endfunction

  // ==========================================================
  // state
  logic                        ack_reg;
  logic                        ack_next;
  logic [ufa_pkg::DAT_W-1:0]   rdat_reg;
  logic [ufa_pkg::DAT_W-1:0]   rdat_next;
  logic [6:0]                  addr_reg;
  logic [6:0]                  addr_next;
  logic [7:0]                  mask_reg;
  logic [7:0]                  mask_next;
  logic                        ring_d_reg;
  logic                        irq_reg;
  logic                        irq_next;
  logic                        nak_reg;
  logic                        nak_next;
  logic                        wake_reg;
  logic                        wake_next;

  // ==========================================================
  // bus decode
  wire req       = I_WB_CYC & I_WB_STB;
  wire take      = req & ack_reg;           // edge the master sees ack
  wire wr_take   = take & I_WB_WE & I_WB_SEL[0];
  wire hit_stat  = idx_hit(I_WB_ADR, ufa_pkg::IDX_EVENT_STATUS);
  wire hit_mask  = idx_hit(I_WB_ADR, ufa_pkg::IDX_EVENT_MASK);
  wire hit_addr  = idx_hit(I_WB_ADR, ufa_pkg::IDX_FUNC_ADDR);
  wire wr_stat   = wr_take & hit_stat;
  wire wr_mask   = wr_take & hit_mask;
  wire wr_addr   = wr_take & hit_addr;

  // ==========================================================
  // event sources
  wire [7:0] status_vec;
  wire       ring_rise = I_EVENTS.ring_level & ~ring_d_reg;
  wire       setup_pend = status_vec[ufa_pkg::BIT_SETUP];

  // hardware set vector, one bit per flag; bit 4 is reserved
  wire [7:0] set_vec;
  assign set_vec[ufa_pkg::BIT_OVERWRITE]  =
    I_EVENTS.setup & setup_pend;
  assign set_vec[ufa_pkg::BIT_WAKEUP]     = I_EVENTS.remote_wake;
  assign set_vec[ufa_pkg::BIT_SETUP]      = I_EVENTS.setup;
  assign set_vec[ufa_pkg::BIT_RING]       = ring_rise;
  assign set_vec[ufa_pkg::BIT_RSV]        = 1'b0;
  assign set_vec[ufa_pkg::BIT_RESUME]     = I_EVENTS.resume;
  assign set_vec[ufa_pkg::BIT_SUSPEND]    = I_EVENTS.suspend;
  assign set_vec[ufa_pkg::BIT_PORT_RESET] = I_EVENTS.port_reset;

  // software only ever clears; write data never reaches a set input
  wire [7:0] clr_vec = wr_stat ? I_WB_DAT[7:0] : 8'h00;

  // next status, mirrored here so outputs track flags without lag
  wire [7:0] status_next = set_vec | (status_vec & ~clr_vec);

  // ==========================================================
  // status flags
  genvar g;
  generate
    for (g = 0; g < ufa_pkg::STATUS_W; g++) begin : g_flag
      ufa_sticky_flag u_flag (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_ce    (I_CE),
        .i_set   (set_vec[g]),
        .i_clear (clr_vec[g]),
        .o_flag  (status_vec[g])
      );
    end
  endgenerate

  // ==========================================================
  // register write paths
  // function reset drops the address but leaves every flag alone
  assign addr_next = I_USB_FUNC_RESET ? ufa_pkg::RST_FUNC_ADDR :
                     wr_addr ? I_WB_DAT[ufa_pkg::FUNC_ADDR_MSB:0] :
                     addr_reg;
  assign mask_next = wr_mask ? I_WB_DAT[7:0] : mask_reg;

  // ==========================================================
  // read mux, registered with ack; reserved bits read zero
  assign rdat_next =
    hit_stat ? {24'h000000, status_vec} :
    hit_mask ? {24'h000000, mask_reg} :
    hit_addr ? {25'h0000000, addr_reg} :
    32'h00000000;

  // one wait state, then ack for exactly one cycle
  assign ack_next = req & ~ack_reg;

  // ==========================================================
  // derived outputs
  assign irq_next  = |(status_next & mask_next);
  assign nak_next  = status_next[ufa_pkg::BIT_SETUP];
  assign wake_next = status_next[ufa_pkg::BIT_RING];

  // ==========================================================
  // bus flops
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else if (I_CE) begin
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // register file flops
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      addr_reg   <= ufa_pkg::RST_FUNC_ADDR;
      mask_reg   <= ufa_pkg::RST_EVENT_MASK;
      ring_d_reg <= 1'b0;
    end else if (I_CE) begin
      addr_reg   <= addr_next;
      mask_reg   <= mask_next;
      ring_d_reg <= I_EVENTS.ring_level;
    end
  end

  // output flops; registered so the pins never glitch
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      irq_reg  <= 1'b0;
      nak_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else if (I_CE) begin
      irq_reg  <= irq_next;
      nak_reg  <= nak_next;
      wake_reg <= wake_next;
    end
  end

  assign O_WB_ACK        = ack_reg;
  assign O_WB_DAT        = rdat_reg;
  assign O_FUNC_ADDR     = addr_reg;
  assign O_IRQ           = irq_reg;
  assign O_EP0_FORCE_NAK = nak_reg;
  assign O_RING_WAKE     = wake_reg;

  // ==========================================================
  // checks
  a_addr_write_lands: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && wr_addr && !I_USB_FUNC_RESET)
      |=> (addr_reg == $past(I_WB_DAT[6:0]))
  ) else $error("function address write did not land");

  a_flag_hw_only: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (status_vec & ~$past(status_vec)) == 8'h00 ||
      ((status_vec & ~$past(status_vec) & ~$past(set_vec)) == 8'h00)
  ) else $error("status flag rose without a hardware event");

  a_rsv_reads_zero: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    !status_vec[ufa_pkg::BIT_RSV]
  ) else $error("reserved status bit is set");

  a_w1c_clears: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && wr_stat && I_WB_DAT[ufa_pkg::BIT_WAKEUP]
      && !set_vec[ufa_pkg::BIT_WAKEUP])
      |=> !status_vec[ufa_pkg::BIT_WAKEUP]
  ) else $error("write one did not clear the flag");

  a_w0_keeps: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && wr_stat && !I_WB_DAT[ufa_pkg::BIT_SUSPEND]
      && status_vec[ufa_pkg::BIT_SUSPEND])
      |=> status_vec[ufa_pkg::BIT_SUSPEND]
  ) else $error("write zero disturbed a flag");

  a_irq_follows: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    $changed(status_vec & mask_reg) && I_CE
      |-> (O_IRQ == |(status_vec & mask_reg))
  ) else $error("interrupt does not match masked flags");

  a_overwrite_set: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.setup && status_vec[ufa_pkg::BIT_SETUP])
      |=> status_vec[ufa_pkg::BIT_OVERWRITE]
  ) else $error("setup overwrite not flagged");

  a_ep0_nak_held: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    status_vec[ufa_pkg::BIT_SETUP] |-> O_EP0_FORCE_NAK
  ) else $error("endpoint 0 not forced to nak");

  a_wake_set: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.remote_wake) |=> status_vec[ufa_pkg::BIT_WAKEUP]
  ) else $error("remote wake-up not flagged");

  a_ring_edge: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.ring_level && !ring_d_reg)
      |=> (status_vec[ufa_pkg::BIT_RING] && O_RING_WAKE)
  ) else $error("ring edge not flagged");

  a_port_reset_kept: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_USB_FUNC_RESET && status_vec[ufa_pkg::BIT_PORT_RESET]
      && !clr_vec[ufa_pkg::BIT_PORT_RESET])
      |=> status_vec[ufa_pkg::BIT_PORT_RESET]
  ) else $error("function reset cleared the reset flag");

  a_ack_single: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && ack_reg) |=> !ack_reg
  ) else $error("ack held longer than one cycle");

  a_ack_needs_req: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && !req) |=> !ack_reg
  ) else $error("ack raised without a request");

  a_clear_by_write: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    ($past(status_vec) & ~status_vec & ~$past(clr_vec)) == 8'h00
  ) else $error("status flag fell without a write of one");

  a_nak_released: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    !status_vec[ufa_pkg::BIT_SETUP] |-> !O_EP0_FORCE_NAK
  ) else $error("endpoint 0 nak held with no setup pending");

  a_wake_follows: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    O_RING_WAKE == status_vec[ufa_pkg::BIT_RING]
  ) else $error("ring wake output does not match the ring flag");

  a_resume_set: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.resume) |=> status_vec[ufa_pkg::BIT_RESUME]
  ) else $error("resume not flagged");

  a_suspend_set: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.suspend) |=> status_vec[ufa_pkg::BIT_SUSPEND]
  ) else $error("suspend not flagged");

  a_port_reset_set: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_EVENTS.port_reset)
      |=> status_vec[ufa_pkg::BIT_PORT_RESET]
  ) else $error("port reset not flagged");

  a_addr_func_reset: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && I_USB_FUNC_RESET) |=> (addr_reg == ufa_pkg::RST_FUNC_ADDR)
  ) else $error("function reset did not drop the address");

  a_unmapped_zero: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_CE && req && !ack_reg && !hit_stat && !hit_mask && !hit_addr)
      |=> (O_WB_DAT == 32'h00000000)
  ) else $error("unmapped read returned nonzero data");

endmodule

// ==== ufa_sticky_flag.sv ====
// Purpose: one sticky event flag, set by hardware, cleared by software
// Assumes: set and clear are single-cycle strobes on the core clock
// Notes:   a set in the clearing cycle wins so no event is lost
`timescale 1ns/1ns
module ufa_sticky_flag (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_ce,
  // control
  input  wire logic i_set,
  input  wire logic i_clear,
  // state
  output logic      o_flag
);

  // ==========================================================
  // flag storage
  logic flag_reg;
  logic flag_next;

  // set has priority over the write-one clear
  assign flag_next = i_set | (flag_reg & ~i_clear);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_reg <= 1'b0;
    end else if (i_ce) begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;

  // ==========================================================
  // checks
  a_set_beats_clear: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_set && i_clear) |=> flag_reg
  ) else $error("flag lost an event during a clear");

endmodule
